// >>> hdl/flash_dev.sv
// Purpose: on-chip flash array with erase/program sequencing, protection and flags
// Assumes: requester holds req_valid until req_ready; one request in flight
// Notes:   array and committed protection model nonvolatile storage (no reset)
// What this block does and expects of its users
// [R1] erase independent 1 kB blocks
// [R2] erased block reads all ones
// [R3] one protection setting per 2 kB region
// [R4] refuse erase/program on read-only regions
// [R5] refuse erase on execute-only, report error
// [R6] execute-only allows fetches, blocks data/debug reads
// [R7] programming only clears bits
// [R8] requester gives word-aligned addresses, whole words
// [R9] requester programs each word once per erase
// [R10] pulses timed by programmed clocks per microsecond
// [R11] disallowed access sets access flag
// [R12] finished erase or program sets done flag
// [R13] enable mask gates flags onto interrupt
// [R14] status readable raw or masked
// [R15] clear request drops selected flags
// [R16] handler should clear flags early
// [R17] temporary protection, irreversible permanent commit
// [R18] protection only tightens; execute-only frozen
// [R19] reset restores committed protection
// [R20] busy while operating, no new requests
// [R21] refused request flags error, array untouched
module flash_dev #(
   parameter int WORDS    = flash_pkg::FLASH_WORDS,
   parameter int ERASE_US = flash_pkg::ERASE_TIME_US,
   parameter int PROG_US  = flash_pkg::PROG_TIME_US
) (
   input  wire logic clk,
   input  wire logic arst_n,
   flash_if.dev      lnk,
   output logic      hv_pulse
);
   import flash_pkg::*;

   localparam int AW   = $clog2(WORDS);
   localparam int BWB  = $clog2(BLOCK_WORDS);
   localparam int RWB  = $clog2(REGION_WORDS);
   localparam int NREG = WORDS / REGION_WORDS;
   localparam int RB   = AW - RWB;

   typedef enum logic [2:0] {ST_LOAD, ST_IDLE, ST_TIME, ST_FILL, ST_DONE} st_t;

   // nonvolatile power-on contents, never reset: blank array, all regions read/write
   logic [31:0] mem        [WORDS] = '{default: ERASED_WORD};
   prot_t       commit_mem [NREG]  = '{default: PROT_RW};
   prot_t       prot_q     [NREG];

   st_t                  state_q;
   logic                 erase_q;
   logic [AW-1:0]        addr_q;
   logic [31:0]          data_q;
   logic [BWB-1:0]       fill_q;
   logic [CLK_CNT_W-1:0] clk_per_us_q;
   logic [CLK_CNT_W-1:0] cyc_q;
   logic [USEC_CNT_W-1:0] usec_q;
   logic [IRQ_W-1:0]     raw_q;
   logic [IRQ_W-1:0]     en_q;
   logic                 rsp_valid_q;
   logic                 rsp_err_q;
   logic [31:0]          rsp_rdata_q;

   // region index of a word address
   function automatic logic [RB-1:0] region_of(input logic [AW-1:0] w);
      return w[AW-1 -: RB];
   endfunction

   // request decode
   logic [29:0]    widx_full;
   logic [AW-1:0]  widx;
   logic           in_range;
   prot_t          cur_prot;
   logic           take;
   logic [1:0]     new_prot;
   logic [USEC_CNT_W-1:0] target_us;
   logic           tick;
   logic           pulse_end;
   logic           op_done;

   assign widx_full = lnk.req_addr[31:2];
   assign widx      = widx_full[AW-1:0];
   assign in_range  = (widx_full < 30'(WORDS));
   assign cur_prot  = prot_q[region_of(widx)]; // R3
   assign take      = lnk.req_valid && lnk.req_ready;
   assign new_prot  = lnk.req_wdata[1:0];
   assign lnk.req_ready = (state_q == ST_IDLE); // R20
   assign lnk.busy      = (state_q != ST_IDLE); // R20

   logic        refuse;
   logic        start;
   logic [31:0] rdata;

   // per-op acceptance check and immediate read data
   always_comb begin
      refuse = 1'b0;
      start  = 1'b0;
      rdata  = 32'h0000_0000;
      case (lnk.req_op)
         OP_FETCH: begin
            refuse = !in_range;
            rdata  = refuse ? 32'h0000_0000 : mem[widx];
         end
         OP_READ, OP_DBG_READ: begin
            refuse = !in_range || (cur_prot == PROT_XO); // R6
            rdata  = refuse ? 32'h0000_0000 : mem[widx];
         end
         OP_ERASE: begin
            // only a block-aligned start address names a block
            refuse = !in_range || (widx[BWB-1:0] != '0) || (cur_prot != PROT_RW); // R1 R4 R5
            start  = !refuse;
         end
         OP_PROGRAM: begin
            refuse = !in_range || (cur_prot != PROT_RW); // R4
            start  = !refuse;
         end
         OP_PROT_SET: begin
            refuse = !in_range || (new_prot == PROT_BAD) || (cur_prot == PROT_XO)
                     || (new_prot < cur_prot); // R18
         end
         OP_PROT_GET: begin
            refuse = !in_range;
            rdata  = {30'h0, cur_prot};
         end
         OP_CLK_SET: refuse = (lnk.req_wdata[CLK_CNT_W-1:0] == '0);
         OP_CLK_GET: rdata = {{(32-CLK_CNT_W){1'b0}}, clk_per_us_q};
         OP_INT_STAT: begin
            rdata = lnk.req_wdata[MASKED_SEL_BIT] ? {30'h0, raw_q & en_q}
                                                  : {30'h0, raw_q}; // R14
         end
         default: ;
      endcase
   end

   // sequencer
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_LOAD;
         erase_q <= 1'b0;
         addr_q  <= '0;
         data_q  <= 32'h0000_0000;
         fill_q  <= '0;
      end else begin
         case (state_q)
            ST_LOAD: state_q <= ST_IDLE;
            ST_IDLE: begin
               if (take && start) begin
                  state_q <= ST_TIME;
                  erase_q <= (lnk.req_op == OP_ERASE);
                  addr_q  <= widx;
                  data_q  <= lnk.req_wdata;
                  fill_q  <= '0;
               end
            end
            ST_TIME: begin
               if (pulse_end) begin
                  state_q <= erase_q ? ST_FILL : ST_DONE;
               end
            end
            ST_FILL: begin
               fill_q <= fill_q + 1'b1;
               if (fill_q == BWB'(BLOCK_WORDS - 1)) begin
                  state_q <= ST_DONE;
               end
            end
            ST_DONE: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   assign op_done  = (state_q == ST_DONE);
   assign hv_pulse = (state_q == ST_TIME);

   // microsecond base from the programmed count; longer erase pulse than program
   assign target_us = erase_q ? USEC_CNT_W'(ERASE_US) : USEC_CNT_W'(PROG_US);
   assign tick      = (cyc_q == clk_per_us_q - 1'b1);
   assign pulse_end = tick && (usec_q == target_us - 1'b1);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cyc_q  <= '0;
         usec_q <= '0;
      end else if (state_q != ST_TIME) begin
         cyc_q  <= '0;
         usec_q <= '0;
      end else if (tick) begin
         cyc_q  <= '0;
         usec_q <= usec_q + 1'b1; // R10
      end else begin
         cyc_q  <= cyc_q + 1'b1; // R10
      end
   end

   // clocks-per-microsecond, software-owned
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         clk_per_us_q <= CLKS_PER_USEC_RST;
      end else if (take && lnk.req_op == OP_CLK_SET && !refuse) begin
         clk_per_us_q <= lnk.req_wdata[CLK_CNT_W-1:0]; // R10
      end
   end

   // array update only after the timed pulse; refused ops never get here
   always_ff @(posedge clk) begin
      if (state_q == ST_FILL) begin
         mem[{addr_q[AW-1:BWB], fill_q}] <= ERASED_WORD; // R1 R2
      end else if (pulse_end && !erase_q) begin
         mem[addr_q] <= mem[addr_q] & data_q; // R7 R21
      end
   end

   // working protection: reloaded from committed copy after every reset
   generate
      for (genvar r = 0; r < NREG; r++) begin : g_prot
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               prot_q[r] <= PROT_RW;
            end else if (state_q == ST_LOAD) begin
               prot_q[r] <= commit_mem[r]; // R19
            end else if (take && lnk.req_op == OP_PROT_SET && !refuse
                         && region_of(widx) == RB'(r)) begin
               prot_q[r] <= prot_t'(new_prot); // R17 R18
            end
         end
         // permanent copy; nothing ever loosens it
         always_ff @(posedge clk) begin
            if (take && lnk.req_op == OP_PROT_COMMIT) begin
               commit_mem[r] <= prot_q[r]; // R17
            end
         end
      end
   endgenerate

   // sticky flags; a new event beats a same-cycle clear
   logic [IRQ_W-1:0] set_v;
   logic [IRQ_W-1:0] clr_v;
   always_comb begin
      set_v = '0;
      set_v[IRQ_DONE_BIT] = op_done; // R12
      set_v[IRQ_ACC_BIT]  = take && refuse; // R11
      clr_v = (take && lnk.req_op == OP_INT_CLR) ? lnk.req_wdata[IRQ_W-1:0] : '0;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         raw_q <= '0;
      end else begin
         raw_q <= (raw_q & ~clr_v) | set_v; // R15
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         en_q <= '0;
      end else if (take && lnk.req_op == OP_INT_EN) begin
         en_q <= lnk.req_wdata[IRQ_W-1:0];
      end
   end

   assign lnk.irq = |(raw_q & en_q); // R13

   // response: immediate ops answer next cycle, erase/program at completion
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rsp_valid_q <= 1'b0;
         rsp_err_q   <= 1'b0;
         rsp_rdata_q <= 32'h0000_0000;
      end else begin
         rsp_valid_q <= (take && !start) || op_done;
         if (take && !start) begin
            rsp_err_q   <= refuse; // R5 R21
            rsp_rdata_q <= rdata;
         end else if (op_done) begin
            rsp_err_q   <= 1'b0;
            rsp_rdata_q <= 32'h0000_0000;
         end
      end
   end

   assign lnk.rsp_valid = rsp_valid_q;
   assign lnk.rsp_err   = rsp_err_q;
   assign lnk.rsp_rdata = rsp_rdata_q;
endmodule

// >>> hdl/flash_host.sv
// Purpose: avalon-mm register front end that issues flash link requests
// Assumes: one command in flight; software polls status or waits on irq
// Notes:   command write stalls with waitrequest while a command is pending
module flash_host (
   input  wire logic                         clk,
   input  wire logic                         arst_n,
   flash_if.host                             lnk,
   input  wire logic [flash_pkg::REG_AW-1:0] avs_address,
   input  wire logic                         avs_read,
   input  wire logic                         avs_write,
   input  wire logic [31:0]                  avs_writedata,
   output logic      [31:0]                  avs_readdata,
   output logic                              avs_waitrequest,
   output logic                              irq
);
   import flash_pkg::*;

   logic [31:0] addr_q;
   logic [31:0] wdata_q;
   logic [31:0] rdata_q;
   logic        req_valid_q;
   op_t         op_q;
   logic        pend_q;
   logic        err_q;
   logic        done_q;
   logic        rd_ack_q;
   logic [31:0] readdata_q;
   logic        cmd_wr;
   logic        op_ok;
   logic        misaligned;

   // reads take one wait cycle so read data come from a flop
   assign avs_waitrequest = (avs_read && !rd_ack_q)
                            || (avs_write && avs_address == REG_CMD && pend_q);
   assign cmd_wr     = avs_write && avs_address == REG_CMD && !pend_q;
   assign op_ok      = (avs_writedata[3:0] <= OP_INT_STAT);
   // aligned program addresses only; checked here so the flash never sees a misaligned program
   assign misaligned = (addr_q[1:0] != 2'h0) && (avs_writedata[3:0] == OP_PROGRAM); // R8

   // software-visible address and data
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         addr_q  <= 32'h0000_0000;
         wdata_q <= 32'h0000_0000;
      end else if (avs_write) begin
         if (avs_address == REG_ADDR) begin
            addr_q <= avs_writedata;
         end
         if (avs_address == REG_WDATA) begin
            wdata_q <= avs_writedata;
         end
      end
   end

   // command issue and completion tracking
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         req_valid_q <= 1'b0;
         op_q        <= OP_FETCH;
         pend_q      <= 1'b0;
         err_q       <= 1'b0;
         done_q      <= 1'b0;
         rdata_q     <= 32'h0000_0000;
      end else if (cmd_wr) begin
         done_q <= 1'b0;
         err_q  <= 1'b0;
         if (!op_ok || misaligned) begin
            err_q  <= 1'b1; // R8
            done_q <= 1'b1;
         end else begin
            req_valid_q <= 1'b1;
            op_q        <= op_t'(avs_writedata[3:0]);
            pend_q      <= 1'b1;
         end
      end else begin
         if (req_valid_q && lnk.req_ready) begin
            req_valid_q <= 1'b0;
         end
         if (pend_q && lnk.rsp_valid) begin
            pend_q  <= 1'b0;
            done_q  <= 1'b1;
            err_q   <= lnk.rsp_err;
            rdata_q <= lnk.rsp_rdata;
         end
      end
   end

   assign lnk.req_valid = req_valid_q;
   assign lnk.req_op    = op_q;
   assign lnk.req_addr  = addr_q;
   assign lnk.req_wdata = wdata_q;
   assign irq           = lnk.irq;

   // registered read port
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_ack_q   <= 1'b0;
         readdata_q <= 32'h0000_0000;
      end else begin
         rd_ack_q <= avs_read && !rd_ack_q;
         if (avs_read && !rd_ack_q) begin
            case (avs_address)
               REG_ADDR:   readdata_q <= addr_q;
               REG_WDATA:  readdata_q <= wdata_q;
               REG_CMD:    readdata_q <= {28'h0, op_q};
               REG_STATUS: readdata_q <= {28'h0, lnk.irq, done_q, err_q, pend_q};
               REG_RDATA:  readdata_q <= rdata_q;
               default:    readdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign avs_readdata = readdata_q;
endmodule

// >>> hdl/flash_if.sv
// Purpose: request/response link between requester and flash controller
// Assumes: both ends on the same clock
// Notes:   one request in flight; response is a one-cycle pulse
interface flash_if;
   import flash_pkg::*;
   logic        req_valid;
   logic        req_ready;
   op_t         req_op;
   logic [31:0] req_addr;
   logic [31:0] req_wdata;
   logic        rsp_valid;
   logic        rsp_err;
   logic [31:0] rsp_rdata;
   logic        busy;
   logic        irq;

   modport dev (
      input  req_valid,
      input  req_op,
      input  req_addr,
      input  req_wdata,
      output req_ready,
      output rsp_valid,
      output rsp_err,
      output rsp_rdata,
      output busy,
      output irq
   );
   modport host (
      output req_valid,
      output req_op,
      output req_addr,
      output req_wdata,
      input  req_ready,
      input  rsp_valid,
      input  rsp_err,
      input  rsp_rdata,
      input  busy,
      input  irq
   );
endinterface

// >>> hdl/flash_pkg.sv
// Purpose: shared constants and types for the flash controller and its requester
// Assumes: 10 MHz system clock, 32-bit words, byte addresses on the link
// Notes:   op codes double as the command register encoding on the requester side
package flash_pkg;
   localparam int CLK_HZ        = 10_000_000;
   localparam int HZ_PER_MHZ    = 1_000_000;
   localparam int CLK_CNT_W     = 8;
   // reset value of the clocks-per-microsecond count, derived from the clock rate
   localparam logic [CLK_CNT_W-1:0] CLKS_PER_USEC_RST = CLK_CNT_W'(CLK_HZ / HZ_PER_MHZ);

   // high-voltage pulse lengths in microseconds
   localparam int ERASE_TIME_US = 20;
   localparam int PROG_TIME_US  = 4;
   localparam int USEC_CNT_W    = 16;

   localparam int WORD_BYTES    = 4;
   localparam int BLOCK_BYTES   = 1024;
   localparam int REGION_BYTES  = 2048;
   localparam int BLOCK_WORDS   = BLOCK_BYTES / WORD_BYTES;
   localparam int REGION_WORDS  = REGION_BYTES / WORD_BYTES;
   localparam int FLASH_WORDS   = 4096;
   localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;

   typedef enum logic [1:0] {
      PROT_RW = 2'h0,
      PROT_RO = 2'h1,
      PROT_XO = 2'h2
   } prot_t;
   localparam logic [1:0] PROT_BAD = 2'h3;

   typedef enum logic [3:0] {
      OP_FETCH       = 4'h0,
      OP_READ        = 4'h1,
      OP_DBG_READ    = 4'h2,
      OP_ERASE       = 4'h3,
      OP_PROGRAM     = 4'h4,
      OP_PROT_SET    = 4'h5,
      OP_PROT_GET    = 4'h6,
      OP_PROT_COMMIT = 4'h7,
      OP_CLK_SET     = 4'h8,
      OP_CLK_GET     = 4'h9,
      OP_INT_EN      = 4'hA,
      OP_INT_CLR     = 4'hB,
      OP_INT_STAT    = 4'hC
   } op_t;

   // interrupt flag positions
   localparam int IRQ_W        = 2;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_ACC_BIT  = 1;
   localparam int MASKED_SEL_BIT = 0;

   // requester register indices (avalon word addresses)
   localparam int REG_AW = 3;
   localparam logic [REG_AW-1:0] REG_ADDR   = 3'h0;
   localparam logic [REG_AW-1:0] REG_WDATA  = 3'h1;
   localparam logic [REG_AW-1:0] REG_CMD    = 3'h2;
   localparam logic [REG_AW-1:0] REG_STATUS = 3'h3;
   localparam logic [REG_AW-1:0] REG_RDATA  = 3'h4;
   localparam int STAT_BUSY = 0;
   localparam int STAT_ERR  = 1;
   localparam int STAT_DONE = 2;
   localparam int STAT_IRQ  = 3;
endpackage

// >>> sim/flash_link_sva.sv
// Purpose: link checks between flash requester and flash device
// Assumes: one clock domain, async active-low reset
// Notes:   protection is internal state, so checks key off responses
module flash_link_sva (
   input wire logic           clk,
   input wire logic           arst_n,
   input wire logic           req_valid,
   input wire logic           req_ready,
   input wire flash_pkg::op_t req_op,
   input wire logic [31:0]    req_wdata,
   input wire logic           rsp_valid,
   input wire logic           rsp_err,
   input wire logic [31:0]    rsp_rdata,
   input wire logic           busy,
   input wire logic           irq,
   input wire logic           hv_pulse
);
   import flash_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);

   logic take;
   op_t  last_op_q;

   // op in flight, needed to judge its response
   assign take = req_valid && req_ready;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) last_op_q <= OP_FETCH;
      else if (take) last_op_q <= req_op;
   end

   busy_blocks_req_a: assert property (busy |-> !req_ready)
      else $error("request accepted while busy");
   rsp_single_a: assert property (rsp_valid |=> !rsp_valid)
      else $error("response longer than one cycle");
   pulse_when_busy_a: assert property (hv_pulse |-> busy)
      else $error("pulse outside an operation");
   // a refused erase or program answers at once with an error, an accepted one runs busy
   long_op_ends_a: assert property (take && req_op inside {OP_ERASE, OP_PROGRAM}
      |=> (rsp_valid && rsp_err) or (busy ##[1:999] rsp_valid))
      else $error("erase or program never finished");
   mask_zero_quiet_a: assert property (take && req_op == OP_INT_EN
      && req_wdata[1:0] == 2'h0 |-> ##2 !irq)
      else $error("interrupt with all sources disabled");
   clear_all_quiet_a: assert property (take && req_op == OP_INT_CLR
      && req_wdata[1:0] == 2'h3 |-> ##2 !irq)
      else $error("interrupt survives a full clear");
   pulse_from_take_a: assert property ($rose(hv_pulse)
      |-> $past(take) && $past(req_op) inside {OP_ERASE, OP_PROGRAM})
      else $error("pulse without erase or program request");
   hidden_read_zero_a: assert property (rsp_valid && rsp_err
      && last_op_q inside {OP_READ, OP_DBG_READ} |-> rsp_rdata == 32'h0)
      else $error("refused read leaks data");
   refused_no_pulse_a: assert property (rsp_valid && rsp_err |-> !$past(hv_pulse))
      else $error("refused request pulsed the array");

   cover property (take && req_op == OP_PROGRAM);
   cover property (take && req_op == OP_ERASE);
   cover property (rsp_valid && rsp_err);
   cover property ($rose(irq));
endmodule

// >>> sim/onchip_flash_controller_test.sv
// Purpose: end-to-end bench of requester and flash device
// Assumes: power-on array all ones, all regions read-write
// Notes:   short pulse parameters; each command checked against a model
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin mismatches++; \
   $display("MISMATCH %s exp=%h got=%h", nm, ex, got); end end
module onchip_flash_controller_test;
   timeunit 1ns;
   timeprecision 1ns;
   import flash_pkg::*;
   localparam int P_US = 1;
   localparam int E_US = 1;

   logic                  clk;
   logic                  arst_n;
   logic [REG_AW-1:0]     avs_address;
   logic                  avs_read;
   logic                  avs_write;
   logic [31:0]           avs_writedata;
   logic [31:0]           avs_readdata;
   logic                  avs_waitrequest;
   logic                  irq;
   logic                  hv_pulse;
   int                    mismatches = 0;
   int                    n_compared = 0;
   int                    cycles = 0;
   int                    hv_cnt = 0;
   // model state: absent word means erased
   logic [31:0]           mem [int];
   logic [1:0]            prot_w [8];
   logic [1:0]            prot_c [8];
   int                    cpu;
   logic [1:0]            flg;
   logic [1:0]            msk;

   flash_if lnk();
   flash_dev #(.ERASE_US(E_US), .PROG_US(P_US)) u_flash_dev (
      .clk(clk), .arst_n(arst_n), .lnk(lnk.dev), .hv_pulse(hv_pulse));
   flash_host u_flash_host (
      .clk(clk), .arst_n(arst_n), .lnk(lnk.host), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
   flash_link_sva u_flash_link_sva (
      .clk(clk), .arst_n(arst_n), .req_valid(lnk.req_valid), .req_ready(lnk.req_ready),
      .req_op(lnk.req_op), .req_wdata(lnk.req_wdata), .rsp_valid(lnk.rsp_valid),
      .rsp_err(lnk.rsp_err), .rsp_rdata(lnk.rsp_rdata), .busy(lnk.busy), .irq(lnk.irq),
      .hv_pulse(hv_pulse));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // pulse length meter; a hang ends in the closing report
   always @(posedge clk) begin
      if (hv_pulse === 1'b1) hv_cnt <= hv_cnt + 1;
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // one avalon transfer; waitrequest sampled at the rising edge that takes it
   task automatic bus(input logic wr, input logic [REG_AW-1:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      avs_address   <= a;
      avs_writedata <= wd;
      avs_write     <= wr;
      avs_read      <= !wr;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge clk);
   endtask

   task automatic do_reset();
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      prot_w = prot_c;
      cpu = int'(CLKS_PER_USEC_RST);
      flg = 2'h0;
      msk = 2'h0;
   endtask

   // issue one command, poll to completion, compare with the model
   task automatic do_op(input logic [3:0] op, input logic [31:0] a, input logic [31:0] wd);
      logic [31:0] st, rd, er, cur;
      logic        ee, cr;
      logic [1:0]  p;
      int          w, r, h0, eh;
      w = int'(a[31:2]);
      r = w / REGION_WORDS;
      p = (r < 8) ? prot_w[r] : 2'h0;
      cur = mem.exists(w) ? mem[w] : ERASED_WORD;
      ee = 1'b0;
      cr = 1'b0;
      er = 32'h0;
      eh = 0;
      h0 = hv_cnt;
      bus(1'b1, REG_ADDR, a, rd);
      bus(1'b1, REG_WDATA, wd, rd);
      bus(1'b1, REG_CMD, {28'h0, op}, rd);
      do bus(1'b0, REG_STATUS, 32'h0, st); while (st[STAT_DONE] !== 1'b1);
      bus(1'b0, REG_RDATA, 32'h0, rd);
      if (op > 4'hC || (op == OP_PROGRAM && a[1:0] != 2'h0)) ee = 1'b1;
      else if (op <= 4'h6 && w >= FLASH_WORDS) begin
         ee = 1'b1;
         flg[1] = 1'b1;
      end else begin
         case (op)
            OP_FETCH, OP_READ, OP_DBG_READ: begin
               ee = (op != OP_FETCH) && (p == PROT_XO);
               er = ee ? 32'h0 : cur;
               cr = 1'b1;
            end
            OP_ERASE: begin
               ee = (a[9:0] != 10'h0) || (p != PROT_RW);
               if (!ee) for (int i = 0; i < BLOCK_WORDS; i++) mem.delete(w + i);
               if (!ee) eh = E_US * cpu;
            end
            OP_PROGRAM: begin
               ee = (p != PROT_RW);
               if (!ee) mem[w] = cur & wd;
               if (!ee) eh = P_US * cpu;
            end
            OP_PROT_SET: begin
               ee = (wd[1:0] == 2'h3) || (p == PROT_XO) || (wd[1:0] < p);
               if (!ee) prot_w[r] = wd[1:0];
            end
            OP_PROT_COMMIT: prot_c = prot_w;
            OP_CLK_SET: begin
               ee = (wd[7:0] == 8'h0);
               if (!ee) cpu = int'(wd[7:0]);
            end
            OP_INT_EN: msk = wd[1:0];
            OP_INT_CLR: flg = flg & ~wd[1:0];
            default: begin
               cr = 1'b1;
               if (op == OP_PROT_GET) er = {30'h0, p};
               else if (op == OP_CLK_GET) er = 32'(cpu);
               else er = {30'h0, wd[0] ? (flg & msk) : flg};
            end
         endcase
         if (ee) flg[1] = 1'b1;
         else if (op == OP_ERASE || op == OP_PROGRAM) flg[0] = 1'b1;
      end
      `CHK("err", ee, st[STAT_ERR])
      if (cr) `CHK("rdata", er, rd)
      `CHK("pulse_cycles", eh, hv_cnt - h0)
      `CHK("irq", |(flg & msk), irq)
      `CHK("status_irq", |(flg & msk), st[STAT_IRQ])
   endtask

   initial begin
      logic [31:0] rd;
      arst_n = 1'b0;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      prot_c = '{default: 2'h0};
      void'($urandom(48));
      do_reset();
      do_op(OP_CLK_GET, 32'h0, 32'h0);
      do_op(OP_INT_EN, 32'h0, 32'h3);
      for (int i = 0; i < 4; i++) do_op(OP_PROGRAM, 32'(4 * i), $urandom());
      do_op(OP_PROGRAM, 32'h400, $urandom());
      for (int i = 0; i < 4; i++) do_op(OP_READ, 32'(4 * i), 32'h0);
      do_op(OP_INT_STAT, 32'h0, 32'h1);
      do_op(OP_INT_CLR, 32'h0, 32'h1);
      do_op(OP_ERASE, 32'h0, 32'h0);
      do_op(OP_READ, 32'h4, 32'h0);
      do_op(OP_FETCH, 32'h400, 32'h0);
      do_op(OP_ERASE, 32'h200, 32'h0);
      do_op(OP_PROGRAM, 32'h402, 32'h0);
      do_op(OP_INT_EN, 32'h0, 32'h1);
      do_op(OP_INT_STAT, 32'h0, 32'h0);
      do_op(OP_INT_STAT, 32'h0, 32'h1);
      do_op(OP_INT_CLR, 32'h0, 32'h3);
      do_op(OP_INT_EN, 32'h0, 32'h3);
      do_op(OP_CLK_SET, 32'h0, 32'h0);
      do_op(OP_INT_EN, 32'h0, 32'h0);
      do_op(OP_INT_EN, 32'h0, 32'h3);
      do_op(OP_CLK_SET, 32'h0, 32'(2 + $urandom_range(18)));
      do_op(OP_PROGRAM, 32'h8, $urandom());
      do_op(OP_CLK_GET, 32'h0, 32'h0);
      do_op(OP_PROT_SET, 32'h800, 32'(PROT_RO));
      do_op(OP_PROT_GET, 32'hC00, 32'h0);
      do_op(OP_PROT_GET, 32'h400, 32'h0);
      do_op(OP_PROGRAM, 32'h800, 32'h0);
      do_op(OP_ERASE, 32'hC00, 32'h0);
      do_op(OP_READ, 32'h800, 32'h0);
      do_op(OP_PROT_SET, 32'h800, 32'(PROT_RW));
      do_op(OP_PROT_SET, 32'h800, 32'(PROT_XO));
      do_op(OP_READ, 32'h804, 32'h0);
      do_op(OP_DBG_READ, 32'h800, 32'h0);
      do_op(OP_FETCH, 32'h800, 32'h0);
      do_op(OP_ERASE, 32'h800, 32'h0);
      do_op(OP_PROT_SET, 32'h800, 32'(PROT_RO));
      do_op(OP_PROT_SET, 32'h1000, 32'h3);
      do_op(OP_READ, 32'h4000, 32'h0);
      do_op(4'hF, 32'h0, 32'h0);
      bus(1'b0, 3'h5, 32'h0, rd);
      `CHK("unmapped", 32'h0, rd)
      for (int i = 0; i < 6; i++) do_op(OP_PROGRAM, 32'h1000 + 32'(4 * i), $urandom());
      for (int i = 0; i < 6; i++) do_op(OP_READ, 32'h1000 + 32'(4 * i), 32'h0);
      do_reset();
      do_op(OP_PROT_GET, 32'h800, 32'h0);
      do_op(OP_CLK_GET, 32'h0, 32'h0);
      do_op(OP_PROT_SET, 32'h3800, 32'(PROT_RO));
      do_op(OP_PROT_COMMIT, 32'h0, 32'h0);
      do_reset();
      do_op(OP_PROT_GET, 32'h3800, 32'h0);
      do_op(OP_PROT_SET, 32'h3800, 32'(PROT_RW));
      tally_and_finish();
   end
endmodule
